// ### logic/tocr_pkg.sv
// Purpose: constants for the trigger-output and panel line register bank
// Assumes: registers addressed by byte offset on the board register port
// Notes: offsets are byte addresses, one 32-bit word each
package tocr_pkg;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam logic [15:0] OFF_TRIG_OUT_MASK = 16'h8110;
   localparam logic [15:0] OFF_POST_TRIG = 16'h8114;
   localparam logic [15:0] OFF_LINES_DATA = 16'h8118;
   localparam logic [15:0] OFF_LINES_CTRL = 16'h811c;
   localparam logic [15:0] OFF_CHAN_EN = 16'h8120;
   localparam logic [15:0] OFF_REVISION = 16'h8124;
   localparam logic [15:0] OFF_EVT_STORED = 16'h812c;
   localparam logic [15:0] OFF_ACQ_CTRL = 16'h8100;
   localparam logic [15:0] OFF_SW_TRIG = 16'h8108;
   localparam logic [15:0] OFF_BUF_FREE = 16'h8010;
   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int MASK_SW_BIT = 31;
   localparam int MASK_EXT_BIT = 30;
   localparam int CTRL_TEST_EN = 15;
   localparam int CTRL_TEST_LVL = 14;
   localparam int CTRL_LATCH_EXT = 9;
   localparam int CTRL_MODE_LO = 6;
   localparam int CTRL_DIR_LO = 2;
   localparam int CTRL_HIZ = 1;
   localparam int CTRL_TTL = 0;
   localparam int ACQ_RUN_BIT = 2;
   // writable bits; the rest read as zero
   localparam logic [31:0] MASK_WMASK = 32'hc00000ff;
   localparam logic [15:0] CTRL_WMASK = 16'hc2ff;
   // -----------------------------------------------------------------
   // reset values and modes
   // -----------------------------------------------------------------
   localparam logic [31:0] RST_ZERO32 = 32'h00000000;
   localparam logic [15:0] RST_ZERO16 = 16'h0000;
   localparam logic [7:0] RST_CHAN_EN = 8'hff;
   localparam logic [1:0] MODE_GPIO = 2'h0;
   localparam logic [1:0] MODE_PROG = 2'h1;
   localparam logic [1:0] MODE_PATTERN = 2'h2;
   // trigger output pulse width in cycles
   localparam logic [3:0] TRIG_PULSE_CYC = 4'h4;
endpackage : tocr_pkg

// ### logic/tocr_post_counter.sv
// Purpose: counts post-trigger samples and fires the internal trigger
// Assumes: one sample per cycle on the strobe input
// Notes: length is four times the setting plus a fixed latency
`timescale 1ns/1ps
module tocr_post_counter #(
   parameter logic [31:0] FIXED_TRIGGER_LATENCY = 32'h0000000a
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic start,
   input wire logic sample_en,
   input wire logic [31:0] post_trigger_value_a,
   // result
   output logic done
);
   typedef struct packed {
      logic busy;
      logic [33:0] count;
      logic done;
   } tocr_pc_state_t;

   tocr_pc_state_t st_reg;
   tocr_pc_state_t st_next;
   logic [33:0] target; // total post samples

   // fixed latency is a constant per build, may differ per revision
   assign target = {post_trigger_value_a, 2'b00}
      + {2'b00, FIXED_TRIGGER_LATENCY};

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.done = 1'b0;
      if (start && !st_reg.busy) begin
         st_next.busy = 1'b1;
         st_next.count = 34'h0;
      end else if (st_reg.busy && sample_en) begin
         // last sample reached: internal trigger fires
         if (st_reg.count + 34'h1 >= target) begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
         end else begin
            st_next.count = st_reg.count + 34'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign done = st_reg.done;
endmodule : tocr_post_counter

// ### logic/tocr_regs.sv
// Purpose: trigger-output, panel line and channel mask register bank
// Assumes: register port strobes are single-cycle, synchronous to CLK
// Notes: read data is registered, valid the cycle after the read strobe
//
// Summary of operation
// - channel mask bits route threshold triggers out
// - bit 30 forwards external trigger out
// - bit 31 forwards software trigger out
// - post samples equal four times value plus latency
// - latency is a per-build constant
// - data register reads lines, writes outputs
// - test mode drives static level from bit14
// - normal mode pulses only on masked triggers
// - bit 9 picks pattern latch moment
// - bits 7:6 select line usage mode
// - bits 5:2 set group directions, gpio only
// - bit 1 tristates trigger and clock outputs
// - bit 0 selects NIM or TTL levels
// - only enabled channels store samples
// - revision reads date, major, minor
// - event counter tracks stored events
// - count never exceeds available buffer blocks
// - run bit starts and stops acquisition
// - any software trigger write fires once
`timescale 1ns/1ps
module tocr_regs #(
   parameter int NCH = 8,
   parameter int NLINES = 16,
   parameter logic [15:0] REV_DATE = 16'h0000, // arbitrary value
   parameter logic [7:0] REV_MAJOR = 8'h01, // arbitrary value
   parameter logic [7:0] REV_MINOR = 8'h00, // arbitrary value
   parameter logic [31:0] FIXED_TRIGGER_LATENCY = 32'h0000000a
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   output logic [31:0] REG_RDATA,
   // trigger sources
   input wire logic [NCH-1:0] CHAN_OVER_THR,
   input wire logic EXT_TRIG,
   input wire logic SAMPLE_EN,
   // buffer bookkeeping
   input wire logic EVENT_DONE,
   input wire logic EVENT_FREED,
   input wire logic [31:0] MAX_BLOCKS,
   // panel lines, oe low while driving
   input wire logic [NLINES-1:0] LINES_IN,
   output logic [NLINES-1:0] LINES_OUT,
   output logic [NLINES-1:0] LINES_OE_N,
   // panel trigger and clock outputs
   output logic TRIGGER_OUTPUT,
   output logic TRIG_CLK_OE_N,
   output logic TTL_LEVELS,
   // acquisition side
   output logic ACQ_RUN,
   output logic [NCH-1:0] CHAN_STORE_EN,
   output logic INTERNAL_TRIG,
   output logic [NLINES-1:0] PATTERN,
   output logic EVENT_STORE_OK
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] out_mask;
      logic [31:0] post_val;
      logic [NLINES-1:0] lines_data;
      logic [15:0] lines_ctrl;
      logic [NCH-1:0] chan_en;
      logic run;
      logic [31:0] evt_count;
      logic [31:0] rdata;
      logic trig_out;
      logic [3:0] pulse_cnt;
      logic ext_d;
      logic [NLINES-1:0] pattern;
      logic [NLINES-1:0] lines_out;
      logic [NLINES-1:0] lines_oe_n;
      logic hiz;
      logic ttl;
      logic store_ok;
      logic [NLINES-1:0] lines_in_q; // registered input levels
   } tocr_state_t;

   tocr_state_t st_reg;
   tocr_state_t st_next;
   logic int_trig; // internal trigger from post counter
   logic sw_trig; // software trigger write strobe
   logic ext_rise; // external trigger rising edge
   logic trig_accept; // any trigger taken while running
   logic mask_hit; // a masked-in trigger for the panel output
   logic [1:0] mode; // line usage mode
   logic [NLINES-1:0] dir_out; // per-line output direction

   // write strobe decode, shared by every register
   function automatic logic wr_hit(input logic [15:0] a,
                                   input logic [15:0] off);
      wr_hit = (a == off);
   endfunction : wr_hit

   // -----------------------------------------------------------------
   // trigger decode
   // -----------------------------------------------------------------
   assign sw_trig = REG_WR && wr_hit(REG_ADDR, tocr_pkg::OFF_SW_TRIG);
   assign ext_rise = EXT_TRIG && !st_reg.ext_d;
   // stop mode neglects all triggers here; masked ones still pulse the panel output
   assign trig_accept = st_reg.run
      && (sw_trig || ext_rise || (|CHAN_OVER_THR));
   assign mask_hit =
      (|(CHAN_OVER_THR & st_reg.out_mask[NCH-1:0]))
      || (ext_rise && st_reg.out_mask[tocr_pkg::MASK_EXT_BIT])
      || (sw_trig && st_reg.out_mask[tocr_pkg::MASK_SW_BIT]);
   assign mode = st_reg.lines_ctrl[tocr_pkg::CTRL_MODE_LO +: 2];

   // group directions: one control bit per four lines
   genvar g;
   generate
      for (g = 0; g < NLINES / 4; g++) begin : gen_dir
         // only general purpose mode honours the groups
         assign dir_out[g*4 +: 4] = {4{mode == tocr_pkg::MODE_GPIO
            && st_reg.lines_ctrl[tocr_pkg::CTRL_DIR_LO + g]}};
      end
   endgenerate

   // -----------------------------------------------------------------
   // post-trigger sample counter
   // -----------------------------------------------------------------
   tocr_post_counter #(
      .FIXED_TRIGGER_LATENCY(FIXED_TRIGGER_LATENCY)
   ) u_post (
      .clk(CLK),
      .rst(RST),
      .start(trig_accept),
      .sample_en(SAMPLE_EN),
      .post_trigger_value_a(st_reg.post_val),
      .done(int_trig)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.ext_d = EXT_TRIG;
      st_next.lines_in_q = LINES_IN;

      // register writes
      if (REG_WR) begin
         if (wr_hit(REG_ADDR, tocr_pkg::OFF_TRIG_OUT_MASK)) begin
            st_next.out_mask = REG_WDATA & tocr_pkg::MASK_WMASK;
         end
         if (wr_hit(REG_ADDR, tocr_pkg::OFF_POST_TRIG)) begin
            st_next.post_val = REG_WDATA;
         end
         if (wr_hit(REG_ADDR, tocr_pkg::OFF_LINES_DATA)) begin
            st_next.lines_data = REG_WDATA[NLINES-1:0];
         end
         if (wr_hit(REG_ADDR, tocr_pkg::OFF_LINES_CTRL)) begin
            st_next.lines_ctrl = REG_WDATA[15:0] & tocr_pkg::CTRL_WMASK;
         end
         // mask frozen while running
         if (wr_hit(REG_ADDR, tocr_pkg::OFF_CHAN_EN) && !st_reg.run) begin
            st_next.chan_en = REG_WDATA[NCH-1:0];
         end
         if (wr_hit(REG_ADDR, tocr_pkg::OFF_ACQ_CTRL)) begin
            st_next.run = REG_WDATA[tocr_pkg::ACQ_RUN_BIT];
         end
      end

      // event count: store increments, free decrements
      if (EVENT_DONE && st_reg.store_ok && !EVENT_FREED) begin
         st_next.evt_count = st_reg.evt_count + 32'h1;
      end else if (EVENT_FREED && !(EVENT_DONE && st_reg.store_ok)
                   && st_reg.evt_count != 32'h0) begin
         st_next.evt_count = st_reg.evt_count - 32'h1;
      end
      // full buffer blocks further storage
      st_next.store_ok = st_next.evt_count < MAX_BLOCKS;

      // trigger output: test level or masked pulses
      if (st_reg.lines_ctrl[tocr_pkg::CTRL_TEST_EN]) begin
         st_next.trig_out = st_reg.lines_ctrl[tocr_pkg::CTRL_TEST_LVL];
         st_next.pulse_cnt = 4'h0;
      end else if (mask_hit) begin
         st_next.trig_out = 1'b1;
         st_next.pulse_cnt = tocr_pkg::TRIG_PULSE_CYC;
      end else if (st_reg.pulse_cnt > 4'h1) begin
         st_next.pulse_cnt = st_reg.pulse_cnt - 4'h1;
      end else begin
         st_next.trig_out = 1'b0;
         st_next.pulse_cnt = 4'h0;
      end

      // pattern latch on external edge or internal trigger
      if (st_reg.lines_ctrl[tocr_pkg::CTRL_LATCH_EXT] ? ext_rise
          : int_trig) begin
         st_next.pattern = LINES_IN;
      end

      // line drivers per usage mode
      unique case (mode)
         tocr_pkg::MODE_GPIO: begin
            st_next.lines_oe_n = ~dir_out;
         end
         tocr_pkg::MODE_PROG: begin
            st_next.lines_oe_n = {NLINES{1'b0}};
         end
         default: begin
            // pattern mode and the unused code: all inputs
            st_next.lines_oe_n = {NLINES{1'b1}};
         end
      endcase
      st_next.lines_out = st_reg.lines_data;
      st_next.hiz = st_reg.lines_ctrl[tocr_pkg::CTRL_HIZ];
      st_next.ttl = st_reg.lines_ctrl[tocr_pkg::CTRL_TTL];

      // read mux
      st_next.rdata = 32'h0;
      if (REG_RD) begin
         unique case (REG_ADDR)
            tocr_pkg::OFF_TRIG_OUT_MASK: st_next.rdata = st_reg.out_mask;
            tocr_pkg::OFF_POST_TRIG: st_next.rdata = st_reg.post_val;
            tocr_pkg::OFF_LINES_DATA: begin
               // live levels of all lines
               st_next.rdata = {16'h0, st_reg.lines_in_q};
            end
            tocr_pkg::OFF_LINES_CTRL: begin
               st_next.rdata = {16'h0, st_reg.lines_ctrl};
            end
            tocr_pkg::OFF_CHAN_EN: begin
               st_next.rdata = {24'h0, st_reg.chan_en};
            end
            tocr_pkg::OFF_REVISION: begin
               st_next.rdata = {REV_DATE, REV_MAJOR, REV_MINOR};
            end
            tocr_pkg::OFF_EVT_STORED: st_next.rdata = st_reg.evt_count;
            tocr_pkg::OFF_ACQ_CTRL: begin
               st_next.rdata = {29'h0, st_reg.run, 2'h0};
            end
            default: st_next.rdata = 32'h0;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         st_reg <= '0;
         st_reg.chan_en <= tocr_pkg::RST_CHAN_EN;
         st_reg.lines_oe_n <= {NLINES{1'b1}};
         st_reg.store_ok <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // -----------------------------------------------------------------
   // outputs, all from flip-flops
   // -----------------------------------------------------------------
   assign REG_RDATA = st_reg.rdata;
   assign LINES_OUT = st_reg.lines_out;
   assign LINES_OE_N = st_reg.lines_oe_n;
   assign TRIGGER_OUTPUT = st_reg.trig_out;
   assign TRIG_CLK_OE_N = st_reg.hiz;
   assign TTL_LEVELS = st_reg.ttl;
   assign ACQ_RUN = st_reg.run;
   assign CHAN_STORE_EN = st_reg.chan_en;
   assign INTERNAL_TRIG = int_trig;
   assign PATTERN = st_reg.pattern;
   assign EVENT_STORE_OK = st_reg.store_ok;
endmodule : tocr_regs

// ### sim/tocr_regs_props.sv
// Purpose: concurrent checks on the trigger-output register bank ports
// Assumes: write shadows mirror what the host put on the register port
// Notes: quiet counts cycles since a mask or control write, saturating
`timescale 1ns/1ps
module tocr_regs_props #(
   parameter logic [15:0] REV_DATE = 16'h0000,
   parameter logic [7:0] REV_MAJOR = 8'h00,
   parameter logic [7:0] REV_MINOR = 8'h00
) (
   // clock and reset
   input wire logic CLK,
   input wire logic RST,
   // register port
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [15:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic [31:0] REG_RDATA,
   // watched outputs
   input wire logic [15:0] LINES_OE_N,
   input wire logic TRIGGER_OUTPUT,
   input wire logic TRIG_CLK_OE_N,
   input wire logic TTL_LEVELS,
   input wire logic ACQ_RUN,
   input wire logic [7:0] CHAN_STORE_EN
);
   // ----------------------------------------------------------------
   // helper shadows
   // ----------------------------------------------------------------
   logic [31:0] mask_sh; // last trigger-output mask written
   logic [15:0] ctrl_sh; // last line control written
   logic [3:0] quiet; // two cycles cover the output flop latency
   logic [15:0] oe_gpio; // enables implied by the group directions
   assign oe_gpio = ~{{4{ctrl_sh[5]}}, {4{ctrl_sh[4]}},
      {4{ctrl_sh[3]}}, {4{ctrl_sh[2]}}};
   // shadow update on every mask or control write
   always_ff @(posedge CLK) begin
      if (RST) begin
         mask_sh <= 32'h0;
         ctrl_sh <= 16'h0;
         quiet <= 4'h0;
      end else begin
         if (REG_WR && REG_ADDR == tocr_pkg::OFF_TRIG_OUT_MASK) begin
            mask_sh <= REG_WDATA;
         end
         if (REG_WR && REG_ADDR == tocr_pkg::OFF_LINES_CTRL) begin
            ctrl_sh <= REG_WDATA[15:0];
         end
         if (REG_WR && (REG_ADDR == tocr_pkg::OFF_TRIG_OUT_MASK ||
               REG_ADDR == tocr_pkg::OFF_LINES_CTRL)) begin
            quiet <= 4'h0;
         end else if (quiet != 4'hf) begin
            quiet <= quiet + 4'h1;
         end
      end
   end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   property p_hiz; quiet > 4'h1 |-> TRIG_CLK_OE_N == ctrl_sh[1]; endproperty
   a_hiz: assert property (p_hiz) else $error("hi-z bit ignored");
   property p_ttl; quiet > 4'h1 |-> TTL_LEVELS == ctrl_sh[0]; endproperty
   a_ttl: assert property (p_ttl) else $error("level bit ignored");
   property p_test;
      quiet > 4'h1 && ctrl_sh[15] |-> TRIGGER_OUTPUT == ctrl_sh[14];
   endproperty
   a_test: assert property (p_test) else $error("test level wrong");
   property p_nomask;
      quiet > 4'h7 && mask_sh == 32'h0 && !ctrl_sh[15] |-> !TRIGGER_OUTPUT;
   endproperty
   a_nomask: assert property (p_nomask) else $error("unmasked out");
   property p_swtrig;
      REG_WR && REG_ADDR == tocr_pkg::OFF_SW_TRIG && mask_sh[31] && ACQ_RUN
         && !ctrl_sh[15] && quiet > 4'h1 |-> ##[1:2] TRIGGER_OUTPUT;
   endproperty
   a_swtrig: assert property (p_swtrig) else $error("sw trig lost");
   property p_oe_gpio;
      quiet > 4'h1 && ctrl_sh[7:6] == tocr_pkg::MODE_GPIO
         |-> LINES_OE_N == oe_gpio;
   endproperty
   a_oe_gpio: assert property (p_oe_gpio) else $error("dir wrong");
   property p_oe_pat;
      quiet > 4'h1 && ctrl_sh[7:6] == tocr_pkg::MODE_PATTERN
         |-> LINES_OE_N == 16'hffff;
   endproperty
   a_oe_pat: assert property (p_oe_pat) else $error("pattern drives");
   property p_rev;
      $past(REG_RD) && $past(REG_ADDR) == tocr_pkg::OFF_REVISION
         |-> REG_RDATA == {REV_DATE, REV_MAJOR, REV_MINOR};
   endproperty
   a_rev: assert property (p_rev) else $error("revision word wrong");
   property p_chan;
      ACQ_RUN && $past(ACQ_RUN) && $past(ACQ_RUN, 2)
         |-> $stable(CHAN_STORE_EN);
   endproperty
   a_chan: assert property (p_chan) else $error("mask moved in run");
endmodule : tocr_regs_props

bind tocr_regs tocr_regs_props #(.REV_DATE(REV_DATE),
   .REV_MAJOR(REV_MAJOR), .REV_MINOR(REV_MINOR)) u_tocr_regs_props (
   .CLK(CLK), .RST(RST), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
   .LINES_OE_N(LINES_OE_N), .TRIGGER_OUTPUT(TRIGGER_OUTPUT),
   .TRIG_CLK_OE_N(TRIG_CLK_OE_N), .TTL_LEVELS(TTL_LEVELS),
   .ACQ_RUN(ACQ_RUN), .CHAN_STORE_EN(CHAN_STORE_EN));

// ### sim/tocr_host.sv
// Purpose: host side of the register port, one word every two cycles
// Assumes: strobes are taken on the rising edge after they rise
// Notes: expected read answers queue here for the bench watcher
`timescale 1ns/1ps
module tocr_host (
   // clock
   input wire logic CLK,
   // register port
   output logic REG_WR,
   output logic REG_RD,
   output logic [15:0] REG_ADDR,
   output logic [31:0] REG_WDATA
);
   logic [31:0] exp_q[$]; // read answers still owed
   // idle bus at time zero
   initial begin
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 16'h0;
      REG_WDATA = 32'h0;
   end
   // hold one edge, then release with inverted leftovers, not stale data
   task automatic xfer(input logic w, input logic [15:0] a,
         input logic [31:0] d);
      @(posedge CLK);
      #1;
      REG_WR = w;
      REG_RD = !w;
      REG_ADDR = a;
      REG_WDATA = d;
      @(posedge CLK);
      #1;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = ~a;
      REG_WDATA = ~d;
   endtask : xfer
   // channel mask is only written while stopped, bar one refusal check
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask : rd
endmodule : tocr_host

// ### sim/test_tocr_regs.sv
// Purpose: self-checking bench for the trigger-output register bank
// Assumes: host model drives the port, bench drives the field side
// Notes: read answers are compared by a watcher off the falling edge
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
   $display("MISMATCH %0t got %0h exp %0h", $time, (a), (e)); end end
module test_tocr_regs;
   localparam logic [31:0] LAT = 32'h6; // short latency keeps runs brief
   localparam logic [15:0] RDATE = 16'h1a2b; // arbitrary value
   localparam logic [7:0] RMAJ = 8'h3c; // arbitrary value
   localparam logic [7:0] RMIN = 8'h4d; // arbitrary value
   int error_cnt;
   int n_tests;
   logic CLK, RST, REG_WR, REG_RD, EXT_TRIG, SAMPLE_EN;
   logic EVENT_DONE, EVENT_FREED, TRIGGER_OUTPUT, TRIG_CLK_OE_N;
   logic TTL_LEVELS, ACQ_RUN, INTERNAL_TRIG, EVENT_STORE_OK, rd_pend;
   logic [15:0] REG_ADDR, LINES_IN, LINES_OUT, LINES_OE_N, PATTERN, ext;
   logic [31:0] REG_WDATA, REG_RDATA, MAX_BLOCKS, got;
   logic [7:0] CHAN_OVER_THR, CHAN_STORE_EN;
   // pad level: far side where released, our driver where enabled
   assign LINES_IN = (ext & LINES_OE_N) | (LINES_OUT & ~LINES_OE_N);
   tocr_regs #(.REV_DATE(RDATE), .REV_MAJOR(RMAJ), .REV_MINOR(RMIN),
      .FIXED_TRIGGER_LATENCY(LAT)) u_tocr_regs (.CLK(CLK), .RST(RST),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
      .CHAN_OVER_THR(CHAN_OVER_THR), .EXT_TRIG(EXT_TRIG),
      .SAMPLE_EN(SAMPLE_EN), .EVENT_DONE(EVENT_DONE),
      .EVENT_FREED(EVENT_FREED), .MAX_BLOCKS(MAX_BLOCKS),
      .LINES_IN(LINES_IN), .LINES_OUT(LINES_OUT), .LINES_OE_N(LINES_OE_N),
      .TRIGGER_OUTPUT(TRIGGER_OUTPUT), .TRIG_CLK_OE_N(TRIG_CLK_OE_N),
      .TTL_LEVELS(TTL_LEVELS), .ACQ_RUN(ACQ_RUN),
      .CHAN_STORE_EN(CHAN_STORE_EN), .INTERNAL_TRIG(INTERNAL_TRIG),
      .PATTERN(PATTERN), .EVENT_STORE_OK(EVENT_STORE_OK));
   tocr_host u_tocr_host (.CLK(CLK), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA));
   // ----------------------------------------------------------------
   // clock, watcher and helpers
   // ----------------------------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #20 CLK = ~CLK;
   end
   // oldest queued answer against the data standing after a read
   always @(negedge CLK) begin
      if (rd_pend) begin
         got = (u_tocr_host.exp_q.size() > 0) ? u_tocr_host.exp_q.pop_front()
            : ~REG_RDATA;
         `CHK(REG_RDATA, got)
      end
      rd_pend = (REG_RD === 1'b1);
   end
   task automatic stop_test;
      if (error_cnt == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask : cyc
   task automatic w(input logic [15:0] a, input logic [31:0] d);
      u_tocr_host.wr(a, d);
   endtask : w
   task automatic r(input logic [15:0] a, input logic [31:0] e);
      u_tocr_host.rd(a, e);
   endtask : r
   // a 4-cycle pulse fits inside the 7-cycle look
   task automatic see_trig(input logic e);
      logic hit;
      hit = 1'b0;
      repeat (7) begin
         cyc(1);
         hit = hit | (TRIGGER_OUTPUT === 1'b1);
      end
      `CHK(hit, e)
   endtask : see_trig
   task automatic thr(input logic [7:0] v);
      CHAN_OVER_THR = v;
      cyc(1);
      CHAN_OVER_THR = 8'h0;
   endtask : thr
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int n;
      {error_cnt, n_tests, rd_pend, EXT_TRIG, SAMPLE_EN} = '0;
      {EVENT_DONE, EVENT_FREED, CHAN_OVER_THR, ext} = '0;
      MAX_BLOCKS = 32'h3;
      RST = 1'b1;
      void'($urandom(32'hc8c4));
      cyc(5);
      RST = 1'b0;
      `CHK(LINES_OE_N, 16'hffff)
      `CHK(CHAN_STORE_EN, tocr_pkg::RST_CHAN_EN)
      r(tocr_pkg::OFF_REVISION, {RDATE, RMAJ, RMIN});
      r(tocr_pkg::OFF_EVT_STORED, 32'h0);
      r(16'h8128, 32'h0);
      w(tocr_pkg::OFF_TRIG_OUT_MASK, 32'hffffffff);
      r(tocr_pkg::OFF_TRIG_OUT_MASK, tocr_pkg::MASK_WMASK);
      w(tocr_pkg::OFF_LINES_CTRL, 32'hffffffff);
      r(tocr_pkg::OFF_LINES_CTRL, {16'h0, tocr_pkg::CTRL_WMASK});
      `CHK({TRIGGER_OUTPUT, TRIG_CLK_OE_N, TTL_LEVELS}, 3'h7)
      w(tocr_pkg::OFF_LINES_CTRL, 32'h8000);
      cyc(2);
      `CHK({TRIGGER_OUTPUT, TRIG_CLK_OE_N, TTL_LEVELS}, 3'h0)
      // trigger routing while running
      w(tocr_pkg::OFF_ACQ_CTRL, 32'h4);
      w(tocr_pkg::OFF_LINES_CTRL, 32'h0);
      w(tocr_pkg::OFF_TRIG_OUT_MASK, 32'h0);
      w(tocr_pkg::OFF_SW_TRIG, $urandom);
      see_trig(1'b0);
      w(tocr_pkg::OFF_TRIG_OUT_MASK, 32'h80000000);
      // one idle edge lets the checker's settle count arm
      cyc(1);
      w(tocr_pkg::OFF_SW_TRIG, $urandom);
      see_trig(1'b1);
      for (int c = 0; c < 8; c++) begin
         w(tocr_pkg::OFF_TRIG_OUT_MASK, 32'h1 << c);
         thr(~(8'h1 << c));
         see_trig(1'b0);
         thr(8'h1 << c);
         see_trig(1'b1);
      end
      for (int m = 1; m >= 0; m--) begin
         w(tocr_pkg::OFF_TRIG_OUT_MASK, 32'(m) << 30);
         EXT_TRIG = 1'b1;
         see_trig(m[0]);
         EXT_TRIG = 1'b0;
      end
      // line modes: general, programmed, pattern
      for (int m = 0; m < 3; m++) begin
         logic [15:0] v, oe;
         v = 16'($urandom);
         ext = ~v;
         oe = (m == 0) ? 16'h0f0f : (m == 1) ? 16'h0000 : 16'hffff;
         w(tocr_pkg::OFF_LINES_CTRL, (32'(m) << 6) | 32'h28);
         w(tocr_pkg::OFF_LINES_DATA, {16'h0, v});
         // driven levels follow the data register one edge later
         cyc(1);
         `CHK(LINES_OE_N, oe)
         `CHK(LINES_OUT & ~oe, v & ~oe)
         r(tocr_pkg::OFF_LINES_DATA, {16'h0, (ext & oe) | (v & ~oe)});
      end
      // pattern on the external edge, then on the internal trigger
      w(tocr_pkg::OFF_LINES_CTRL, 32'h280);
      ext = 16'($urandom);
      EXT_TRIG = 1'b1;
      cyc(3);
      `CHK(PATTERN, ext)
      EXT_TRIG = 1'b0;
      w(tocr_pkg::OFF_LINES_CTRL, 32'h80);
      w(tocr_pkg::OFF_POST_TRIG, 32'h2);
      r(tocr_pkg::OFF_POST_TRIG, 32'h2);
      SAMPLE_EN = 1'b1;
      cyc(30);
      ext = 16'($urandom);
      w(tocr_pkg::OFF_SW_TRIG, 32'h0);
      n = 0;
      while (INTERNAL_TRIG !== 1'b1 && n < 40) begin
         cyc(1);
         n++;
      end
      `CHK((n >= 8 + LAT) && (n <= 11 + LAT), 1'b1)
      if (n >= 40) stop_test();
      cyc(1);
      `CHK(PATTERN, ext)
      // channel mask only moves while stopped
      w(tocr_pkg::OFF_ACQ_CTRL, 32'h0);
      w(tocr_pkg::OFF_CHAN_EN, 32'h5a);
      cyc(1);
      `CHK(CHAN_STORE_EN, 8'h5a)
      w(tocr_pkg::OFF_ACQ_CTRL, 32'h4);
      w(tocr_pkg::OFF_CHAN_EN, 32'h0f);
      r(tocr_pkg::OFF_CHAN_EN, 32'h5a);
      `CHK({ACQ_RUN, CHAN_STORE_EN}, 9'h15a)
      // event count saturates at the block limit
      repeat (4) begin
         EVENT_DONE = 1'b1;
         cyc(1);
         EVENT_DONE = 1'b0;
         cyc(1);
      end
      r(tocr_pkg::OFF_EVT_STORED, 32'h3);
      `CHK(EVENT_STORE_OK, 1'b0)
      EVENT_FREED = 1'b1;
      cyc(1);
      EVENT_FREED = 1'b0;
      r(tocr_pkg::OFF_EVT_STORED, 32'h2);
      `CHK(EVENT_STORE_OK, 1'b1)
      cyc(3);
      stop_test();
   end
endmodule : test_tocr_regs
